// ===== dlc_core.sv
// Dark level subtraction and column noise cancellation pixel path
//
// Contract
// - Auto level sums selected dark pixel count
// - Enable bit subtracts black level per pixel
// - Manual bit freezes level to written value
// - Count code halves 8096 down to 64
// - Dark pixels clipped before accumulating
// - Error flag when dark pixels too few
// - Level applies to rest of frame
// - Quick settle outputs black, settles table
// - Reference source: test voltage or row
// - Column sample averaged, stored, subtracted
// - Peak mode adds max minus column
// - Average mode adds mean, saturates both
// - Average clip lowers ceiling to full minus mean
// - Smoothing low-pass updates column table
// - Dump outputs table on first blank row
// - Horizontal combine codes 000 001 011
// - Vertical combine codes 000 to 100
`timescale 1ns/100ps
module dlc_core #(
	parameter int NUM_COLS = 2080,
	parameter int COL_W    = 12
) (
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	// Register port
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic [7:0]       reg_wdata_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	output logic      [7:0]       reg_rdata_o,
	// Pixel input from array readout
	input  wire dlc_pkg::dlc_pix_t pix_i,
	// Pixel output to back end
	output dlc_pkg::dlc_pix_t     pix_o,
	// Analog combine factors to the array
	output logic      [2:0]       horiz_combine_factor_o,
	output logic      [2:0]       vert_combine_factor_o
);
	// Registers
	logic [15:0] black_level_value_reg;
	logic [7:0]  dark_ctrl_reg;
	logic [7:0]  column_noise_control_reg;
	logic [2:0]  horiz_reg;
	logic [2:0]  vert_reg;
	logic [7:0]  rdata_reg;
	// Dark accumulation
	logic [25:0] dark_sum_reg;
	logic [13:0] dark_cnt_reg;
	logic [11:0] auto_level_reg;
	logic        dark_error_reg;
	// Column table and statistics
	logic [COL_W-1:0] col_table [NUM_COLS];
	logic [COL_W-1:0] col_peak_reg;
	logic [COL_W+11:0] col_sum_reg;
	logic [COL_W-1:0] column_mean_value_reg;
	logic [COL_W-1:0] peak_run_reg;
	logic [COL_W+11:0] sum_run_reg;
	logic [COL_W+9:0] col_acc [NUM_COLS];
	logic [9:0]  blank_rows_reg;
	logic        first_blank_reg;
	logic        was_blank_reg;
	dlc_pkg::dlc_pix_t pix_reg;

	// Field decode
	wire         manual_level  = black_level_value_reg[dlc_pkg::BIT_MANUAL_LEVEL];
	wire         dark_sub_en   = dark_ctrl_reg[dlc_pkg::BIT_DARK_SUB_EN];
	wire  [2:0]  dark_sample_count_sel = dark_ctrl_reg[2:0];
	wire         quick_settle  = column_noise_control_reg[dlc_pkg::BIT_QUICK_SETTLE];
	wire         ref_source    = column_noise_control_reg[dlc_pkg::BIT_REF_SOURCE];
	wire         table_dump    = column_noise_control_reg[dlc_pkg::BIT_TABLE_DUMP];
	wire         peak_mode     = column_noise_control_reg[dlc_pkg::BIT_PEAK_MODE];
	wire         smoothing_en  = column_noise_control_reg[dlc_pkg::BIT_SMOOTHING_EN];
	wire         avg_clip_en   = column_noise_control_reg[dlc_pkg::BIT_AVG_CLIP_EN];
	wire         cancel_en     = column_noise_control_reg[dlc_pkg::BIT_CANCEL_EN];

	// Count target: code 0 is 8096, each code halves from 4096 down to 64
	function automatic logic [13:0] dark_target(input logic [2:0] code);
		dark_target = (code == 3'h0) ? dlc_pkg::DARK_COUNT_FULL
			: 14'(dlc_pkg::DARK_COUNT_BASE >> code);
	endfunction : dark_target

	// Divide by target as a shift; code 0 treated as 8192 to avoid a divider
	function automatic logic [11:0] dark_mean(input logic [25:0] s, input logic [2:0] c);
		logic [25:0] q;
		q = s >> (5'd13 - {2'b00, c});
		dark_mean = q[11:0];
	endfunction : dark_mean

	// Dark pixel clip window
	wire  [11:0] dark_clipped = (pix_i.data > dlc_pkg::DARK_CLIP_HIGH)
		? dlc_pkg::DARK_CLIP_HIGH : pix_i.data;
	wire  [13:0] target       = dark_target(dark_sample_count_sel);
	wire         dark_take    = pix_i.valid && pix_i.dark_top && (dark_cnt_reg < target);
	wire         dark_done    = dark_take && (dark_cnt_reg == target - 14'd1);
	// Frame start pixel is itself the first dark sample; dropping it would starve the count
	wire         dark_first   = pix_i.valid && pix_i.frame_start && pix_i.dark_top
		&& !manual_level;

	// Level in use: manual or automatic
	wire  [11:0] level_used   = manual_level ? black_level_value_reg[15:4]
		: auto_level_reg;

	// Column reference sample: test voltage rows or bottom dark row
	wire         ref_row      = ref_source ? pix_i.vblank
		: pix_i.dark_bottom;
	wire         ref_take     = pix_i.valid && ref_row;
	wire  [11:0] col_idx      = (pix_i.col < 12'(NUM_COLS)) ? pix_i.col : 12'h000;
	wire  [COL_W-1:0] col_val = col_table[col_idx];
	wire  [COL_W+9:0] acc_cur = col_acc[col_idx];
	wire  [COL_W+9:0] acc_new = (pix_i.vblank && !was_blank_reg) ? {10'h000, pix_i.data}
		: acc_cur + {10'h000, pix_i.data};
	wire         blank_end    = was_blank_reg && !pix_i.vblank && pix_i.valid;
	wire  [9:0]  rows_div     = (blank_rows_reg == 10'h000) ? 10'h001 : blank_rows_reg;

	// Dark subtraction stage, floor at zero
	wire  [12:0] dark_diff    = {1'b0, pix_i.data} - {1'b0, level_used};
	wire  [11:0] dark_out     = !dark_sub_en ? pix_i.data
		: (dark_diff[12] ? 12'h000 : dark_diff[11:0]);

	// Column correction: input plus offset minus column value
	wire  [COL_W-1:0] offset  = peak_mode ? col_peak_reg : column_mean_value_reg;
	wire  signed [14:0] corr  = $signed({3'b000, dark_out}) + $signed({3'b000, offset})
		- $signed({3'b000, col_val});
	wire  [11:0] sat_max      = (!peak_mode && avg_clip_en)
		? 12'(dlc_pkg::PIXEL_FULL_SCALE - column_mean_value_reg)
		: dlc_pkg::PIXEL_FULL_SCALE;
	wire  [11:0] col_out      = (corr < 0) ? 12'h000
		: (corr > $signed({3'b000, sat_max})) ? sat_max : corr[11:0];
	wire  [11:0] pix_next     = quick_settle ? 12'h000
		: (table_dump && first_blank_reg && pix_i.vblank) ? col_val
		: cancel_en ? col_out : dark_out;

	// Reserved analog combine codes are ignored on write
	function automatic logic h_code_ok(input logic [2:0] c);
		h_code_ok = (c == 3'h0) || (c == 3'h1) || (c == 3'h3);
	endfunction : h_code_ok
	function automatic logic v_code_ok(input logic [2:0] c);
		v_code_ok = (c <= 3'h4);
	endfunction : v_code_ok

	// Register read mux
	wire  [7:0] rd_mux =
		(reg_addr_i == dlc_pkg::ADDR_BLACK_LEVEL_HI) ? black_level_value_reg[15:8] :
		(reg_addr_i == dlc_pkg::ADDR_BLACK_LEVEL_LO) ? black_level_value_reg[7:0] :
		(reg_addr_i == dlc_pkg::ADDR_DARK_CTRL)
			? {dark_ctrl_reg[7], dark_error_reg, 3'b000, dark_ctrl_reg[2:0]} :
		(reg_addr_i == dlc_pkg::ADDR_COLUMN_CTRL) ? {1'b0, column_noise_control_reg[6:0]} :
		(reg_addr_i == dlc_pkg::ADDR_ANALOG_COMBINE) ? {1'b0, horiz_reg, 1'b0, vert_reg} :
		8'h00;

	// Register writes; manual bit locks the level readback to software value
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			black_level_value_reg    <= dlc_pkg::BLACK_LEVEL_RESET;
			dark_ctrl_reg            <= 8'h00;
			column_noise_control_reg <= dlc_pkg::COLUMN_CTRL_RESET;
			horiz_reg                <= 3'h0;
			vert_reg                 <= 3'h0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				dlc_pkg::ADDR_BLACK_LEVEL_HI: black_level_value_reg[15:8] <= reg_wdata_i;
				dlc_pkg::ADDR_BLACK_LEVEL_LO: black_level_value_reg[7:0] <= reg_wdata_i;
				dlc_pkg::ADDR_DARK_CTRL: dark_ctrl_reg <= {reg_wdata_i[7], 4'h0, reg_wdata_i[2:0]};
				dlc_pkg::ADDR_COLUMN_CTRL: column_noise_control_reg <= {1'b0, reg_wdata_i[6:0]};
				dlc_pkg::ADDR_ANALOG_COMBINE: begin
					if (h_code_ok(reg_wdata_i[6:4])) horiz_reg <= reg_wdata_i[6:4];
					if (v_code_ok(reg_wdata_i[2:0])) vert_reg <= reg_wdata_i[2:0];
				end
				default: ;
			endcase
		end else if (!manual_level) begin
			black_level_value_reg[15:4] <= auto_level_reg; // Shows computed level
		end
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) rdata_reg <= 8'h00;
		else rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
	end

	// Dark accumulation restarts each frame; level updates on completion
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			dark_sum_reg   <= 26'h0;
			dark_cnt_reg   <= 14'h0;
			auto_level_reg <= 12'h000;
			dark_error_reg <= 1'b0;
		end else if (pix_i.valid && pix_i.frame_start) begin
			// Too few dark pixels in the last frame raises the flag
			dark_error_reg <= (dark_cnt_reg < target);
			dark_sum_reg   <= dark_first ? {14'h0, dark_clipped} : 26'h0;
			dark_cnt_reg   <= dark_first ? 14'd1 : 14'h0;
		end else if (dark_take && !manual_level) begin
			dark_sum_reg <= dark_sum_reg + {14'h0, dark_clipped};
			dark_cnt_reg <= dark_cnt_reg + 14'd1;
			if (dark_done) auto_level_reg <= dark_mean(dark_sum_reg
				+ {14'h0, dark_clipped}, dark_sample_count_sel);
		end
	end

	// Vertical blank tracking for column sampling
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			was_blank_reg   <= 1'b0;
			first_blank_reg <= 1'b0;
			blank_rows_reg  <= 10'h000;
		end else if (pix_i.valid) begin
			was_blank_reg <= pix_i.vblank;
			if (pix_i.vblank && !was_blank_reg) begin
				first_blank_reg <= 1'b1;
				blank_rows_reg  <= 10'h001;
			end else if (pix_i.vblank && pix_i.row_start) begin
				first_blank_reg <= 1'b0;
				blank_rows_reg  <= blank_rows_reg + 10'h001;
			end
		end
	end

	// Per-column accumulator over reference rows, blanking or bottom dark; table load at blank end
	always_ff @(posedge sys_clk_i) begin
		if (ref_take) col_acc[col_idx] <= acc_new;
	end

	// Averaged sample written direct, smoothed, or forced when settling
	wire  [COL_W+9:0] avg_full = acc_cur / {{COL_W{1'b0}}, rows_div};
	wire  [COL_W-1:0] avg_col  = avg_full[COL_W-1:0];
	wire  [COL_W-1:0] lpf_col  = COL_W'(col_val
		+ COL_W'($signed({1'b0, avg_col} - {1'b0, col_val}) >>> dlc_pkg::SMOOTH_SHIFT));
	wire  [COL_W-1:0] new_col  = (smoothing_en && !quick_settle) ? lpf_col
		: avg_col;
	wire              tbl_wr   = cancel_en && pix_i.valid && !pix_i.vblank
		&& was_blank_reg && !pix_i.dark_top;

	// Table update uses the column address of the first pixel after blanking
	always_ff @(posedge sys_clk_i) begin
		if (tbl_wr && pix_i.row_start == 1'b0 && blank_end == 1'b0)
			col_table[col_idx] <= new_col;
		else if (blank_end)
			col_table[col_idx] <= new_col;
	end

	// Peak and mean across columns, latched per frame
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			peak_run_reg          <= '0;
			sum_run_reg           <= '0;
			col_peak_reg          <= '0;
			col_sum_reg           <= '0;
			column_mean_value_reg <= '0;
		end else if (pix_i.valid && pix_i.frame_start) begin
			col_peak_reg          <= peak_run_reg;
			col_sum_reg           <= sum_run_reg;
			column_mean_value_reg <= COL_W'(sum_run_reg / (COL_W+12)'(NUM_COLS));
			peak_run_reg          <= '0;
			sum_run_reg           <= '0;
		end else if (pix_i.valid && !pix_i.vblank && !pix_i.dark_top) begin
			if (col_val > peak_run_reg) peak_run_reg <= col_val;
			sum_run_reg <= sum_run_reg + {12'h000, col_val};
		end
	end

	// Output stage
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pix_reg <= '0;
		end else begin
			pix_reg      <= pix_i;
			pix_reg.data <= pix_next;
		end
	end

	assign reg_rdata_o            = rdata_reg;
	assign pix_o                  = pix_reg;
	assign horiz_combine_factor_o = horiz_reg;
	assign vert_combine_factor_o  = vert_reg;
endmodule : dlc_core

// ===== dlc_pkg.sv
// Package for the dark level and column noise correction block
package dlc_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_BLACK_LEVEL_HI = 8'h30;
	localparam logic [7:0] ADDR_BLACK_LEVEL_LO = 8'h31;
	localparam logic [7:0] ADDR_DARK_CTRL      = 8'h32;
	localparam logic [7:0] ADDR_COLUMN_CTRL    = 8'h33;
	localparam logic [7:0] ADDR_ANALOG_COMBINE = 8'h35;
	// Field positions
	localparam int BIT_MANUAL_LEVEL  = 0;
	localparam int BIT_DARK_SUB_EN   = 7;
	localparam int BIT_DARK_ERROR    = 6;
	localparam int BIT_QUICK_SETTLE  = 6;
	localparam int BIT_REF_SOURCE    = 5;
	localparam int BIT_TABLE_DUMP    = 4;
	localparam int BIT_PEAK_MODE     = 3;
	localparam int BIT_SMOOTHING_EN  = 2;
	localparam int BIT_AVG_CLIP_EN   = 1;
	localparam int BIT_CANCEL_EN     = 0;
	// Reset values
	localparam logic [7:0]  COLUMN_CTRL_RESET = 8'h2E;
	localparam logic [15:0] BLACK_LEVEL_RESET = 16'h0000;
	localparam logic [11:0] PIXEL_FULL_SCALE  = 12'hFFF;
	// Dark sample counts
	localparam logic [13:0] DARK_COUNT_FULL = 14'd8096;
	localparam logic [13:0] DARK_COUNT_BASE = 14'd8192;
	// Dark pixel clip window
	localparam logic [11:0] DARK_CLIP_LOW  = 12'h000;
	localparam logic [11:0] DARK_CLIP_HIGH = 12'h3FF;
	// Smoothing filter shift
	localparam int SMOOTH_SHIFT = 4;
	// Pixel stream carrier
	typedef struct packed {
		logic        valid;
		logic        frame_start;
		logic        row_start;
		logic        dark_top;
		logic        dark_bottom;
		logic        vblank;
		logic [11:0] col;
		logic [11:0] data;
	} dlc_pix_t;
endpackage : dlc_pkg

// ===== dlc_core_monitor.sv
// Port checker for the correction pixel path
`timescale 1ns/100ps
module dlc_core_monitor (
	// Clock and reset
	input wire logic              sys_clk_i,
	input wire logic              rst_i,
	// Register port
	input wire logic [7:0]        reg_addr_i,
	input wire logic [7:0]        reg_wdata_i,
	input wire logic              reg_wr_i,
	input wire logic              reg_rd_i,
	input wire logic [7:0]        reg_rdata_o,
	// Pixel streams
	input wire dlc_pkg::dlc_pix_t pix_i,
	input wire dlc_pkg::dlc_pix_t pix_o,
	// Analog combine factors
	input wire logic [2:0]        horiz_combine_factor_o,
	input wire logic [2:0]        vert_combine_factor_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Shadows of written controls, so readback and flush can be judged from ports
	logic [7:0] col_reg;
	logic [3:0] dk_reg;
	wire        col_wr = reg_wr_i && reg_addr_i == dlc_pkg::ADDR_COLUMN_CTRL;
	wire        dk_wr  = reg_wr_i && reg_addr_i == dlc_pkg::ADDR_DARK_CTRL;
	wire        ab_wr  = reg_wr_i && reg_addr_i == dlc_pkg::ADDR_ANALOG_COMBINE;
	wire [2:0]  h_new  = reg_wdata_i[6:4];
	wire [2:0]  v_new  = reg_wdata_i[2:0];
	wire        h_ok   = h_new == 3'h0 || h_new == 3'h1 || h_new == 3'h3;
	wire        plain  = !dk_reg[3] && !col_reg[6] && !col_reg[4] && !col_reg[0];
	// Shadow update
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			col_reg <= dlc_pkg::COLUMN_CTRL_RESET;
			dk_reg  <= 4'h0;
		end else begin
			if (col_wr) col_reg <= reg_wdata_i;
			if (dk_wr) dk_reg <= {reg_wdata_i[7], reg_wdata_i[2:0]};
		end
	end
	// Steps shared by the properties
	sequence s_rd(logic [7:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	sequence s_ab_wr(logic ok);
		ab_wr && ok;
	endsequence
	property p_rd_idle;
		!reg_rd_i |=> reg_rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
	property p_col_rd;
		s_rd(dlc_pkg::ADDR_COLUMN_CTRL) |=> reg_rdata_o == {1'b0, col_reg[6:0]};
	endproperty
	a_col_rd: assert property (p_col_rd) else $error("column control readback wrong");
	property p_dk_rd;
		s_rd(dlc_pkg::ADDR_DARK_CTRL) |=> {reg_rdata_o[7], reg_rdata_o[2:0]} == dk_reg
			&& reg_rdata_o[5:3] == 3'h0;
	endproperty
	a_dk_rd: assert property (p_dk_rd) else $error("dark control readback wrong");
	property p_h_ok;
		s_ab_wr(h_ok) |=> horiz_combine_factor_o == $past(h_new);
	endproperty
	a_h_ok: assert property (p_h_ok) else $error("horizontal factor not taken");
	property p_h_res;
		s_ab_wr(!h_ok) |=> $stable(horiz_combine_factor_o);
	endproperty
	a_h_res: assert property (p_h_res) else $error("reserved horizontal code taken");
	property p_v_ok;
		s_ab_wr(v_new <= 3'h4) |=> vert_combine_factor_o == $past(v_new);
	endproperty
	a_v_ok: assert property (p_v_ok) else $error("vertical factor not taken");
	property p_v_res;
		s_ab_wr(v_new > 3'h4) |=> $stable(vert_combine_factor_o);
	endproperty
	a_v_res: assert property (p_v_res) else $error("reserved vertical code taken");
	property p_pix_lat;
		pix_i.valid |=> pix_o.valid && pix_o.col == $past(pix_i.col);
	endproperty
	a_pix_lat: assert property (p_pix_lat) else $error("pixel lost or moved");
	property p_flush;
		col_reg[dlc_pkg::BIT_QUICK_SETTLE] && pix_i.valid |=> pix_o.data == 12'h000;
	endproperty
	a_flush: assert property (p_flush) else $error("image shown during settle");
	property p_bypass;
		plain && pix_i.valid |=> pix_o.data == $past(pix_i.data);
	endproperty
	a_bypass: assert property (p_bypass) else $error("pixel altered with corrections off");
endmodule : dlc_core_monitor

bind dlc_core dlc_core_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pix_i(pix_i), .pix_o(pix_o),
	.horiz_combine_factor_o(horiz_combine_factor_o),
	.vert_combine_factor_o(vert_combine_factor_o));

// ===== dlc_sink.sv
// Back-end processor model taking the corrected pixel stream
`timescale 1ns/100ps
module dlc_sink (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	// Pixel stream and frame discard request
	input  wire dlc_pkg::dlc_pix_t pix_i,
	input  wire logic              discard_i,
	// Last pixel seen and count of pixels kept
	output logic      [15:0]       last_o,
	output logic      [15:0]       kept_o
);
	// Every pixel is seen, but pixels under a discard request are not kept
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			last_o <= 16'h0000;
			kept_o <= 16'h0000;
		end else if (pix_i.valid) begin
			last_o <= {4'h0, pix_i.data};
			if (!discard_i) kept_o <= kept_o + 16'h0001;
		end
	end
endmodule : dlc_sink

// ===== tb_dlc_core.sv
// Self-checking bench for the correction pixel path
`timescale 1ns/100ps
module tb_dlc_core;
	logic              sys_clk_i   = 1'b0;
	logic              rst_i       = 1'b1;
	logic [7:0]        reg_addr_i  = 8'h00;
	logic [7:0]        reg_wdata_i = 8'h00;
	logic              reg_wr_i    = 1'b0;
	logic              reg_rd_i    = 1'b0;
	logic [7:0]        reg_rdata_o;
	dlc_pkg::dlc_pix_t pix_i       = '0;
	dlc_pkg::dlc_pix_t pix_o;
	logic [2:0]        horiz_o;
	logic [2:0]        vert_o;
	logic              discard     = 1'b0;
	logic [15:0]       last;
	logic [15:0]       kept;
	logic [15:0]       kept_before;
	logic [15:0]       rd;
	logic [2:0]        eh;
	logic [2:0]        ev;
	int                error_cnt   = 0;
	int                n_compared  = 0;
	// 25 MHz clock
	initial forever #20 sys_clk_i = ~sys_clk_i;
	dlc_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .pix_i(pix_i), .pix_o(pix_o),
		.horiz_combine_factor_o(horiz_o), .vert_combine_factor_o(vert_o));
	dlc_sink u_sink (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pix_i(pix_o),
		.discard_i(discard), .last_o(last), .kept_o(kept));
	// Register bus: one-cycle strobes, read data taken in the cycle after
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i    <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i   <= 1'b0;
		#1 rd = {8'h00, reg_rdata_o};
	endtask : rdr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One pixel, then a gap cycle so valid never changes twice in a step
	task automatic px(input logic fs, input logic dk, input logic [11:0] c, input logic [11:0] d);
		@(posedge sys_clk_i);
		pix_i <= '{1'b1, fs, 1'b0, dk, 1'b0, 1'b0, c, d};
		@(posedge sys_clk_i);
		pix_i.valid <= 1'b0;
	endtask : px
	// Frame start with 64 dark pixels, above the dark clip window on purpose
	task automatic frame();
		for (int i = 0; i < 64; i++) px(i == 0, 1'b1, 12'(i), 12'h7FF);
	endtask : frame
	// The sink holds the pixel one edge after the design answers
	task automatic chkpx(input logic [15:0] exp);
		@(posedge sys_clk_i);
		#1 chk(last, exp);
	endtask : chkpx
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	// Watchdog: the tests need about 500 cycles, this allows 5000
	initial begin
		#200000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rdr(dlc_pkg::ADDR_COLUMN_CTRL);
		chk(rd, 16'h002E);
		wr(8'h40, 8'hFF);
		rdr(8'h40);
		chk(rd, 16'h0000);
		$display("test reset values done");
		eh = 3'h0;
		ev = 3'h0;
		for (int i = 0; i < 8; i++) begin
			wr(dlc_pkg::ADDR_ANALOG_COMBINE, {1'b0, 3'(i), 1'b0, 3'(i)});
			if (i < 2 || i == 3) eh = 3'(i);
			if (i < 5) ev = 3'(i);
			rdr(dlc_pkg::ADDR_ANALOG_COMBINE);
			chk(rd, {9'h000, eh, 1'b0, ev});
			chk({13'h0000, horiz_o}, {13'h0000, eh});
			chk({13'h0000, vert_o}, {13'h0000, ev});
		end
		for (int i = 0; i < 8; i++) begin
			wr(dlc_pkg::ADDR_DARK_CTRL, {5'h00, 3'(i)});
			rdr(dlc_pkg::ADDR_DARK_CTRL);
			chk(rd & 16'hFFBF, {13'h0000, 3'(i)});
		end
		$display("test field codes done");
		wr(dlc_pkg::ADDR_BLACK_LEVEL_LO, 8'h00);
		wr(dlc_pkg::ADDR_COLUMN_CTRL, 8'h00);
		wr(dlc_pkg::ADDR_DARK_CTRL, 8'h87);
		frame();
		px(1'b0, 1'b0, 12'h040, 12'h800);
		chkpx(16'h0401);
		rdr(dlc_pkg::ADDR_BLACK_LEVEL_HI);
		chk(rd, 16'h003F);
		wr(dlc_pkg::ADDR_DARK_CTRL, 8'h86);
		frame();
		rdr(dlc_pkg::ADDR_DARK_CTRL);
		chk(rd, 16'h00C6);
		$display("test automatic level done");
		// Low byte first: the manual bit must be set before the level byte lands
		wr(dlc_pkg::ADDR_BLACK_LEVEL_LO, 8'h31);
		wr(dlc_pkg::ADDR_BLACK_LEVEL_HI, 8'h12);
		wr(dlc_pkg::ADDR_DARK_CTRL, 8'h87);
		frame();
		px(1'b0, 1'b0, 12'h040, 12'h500);
		chkpx(16'h03DD);
		rdr(dlc_pkg::ADDR_DARK_CTRL);
		chk(rd, 16'h0087);
		rdr(dlc_pkg::ADDR_BLACK_LEVEL_LO);
		chk(rd, 16'h0031);
		wr(dlc_pkg::ADDR_DARK_CTRL, 8'h07);
		px(1'b0, 1'b0, 12'h041, 12'h500);
		chkpx(16'h0500);
		$display("test manual level done");
		wr(dlc_pkg::ADDR_COLUMN_CTRL, 8'h40);
		discard <= 1'b1;
		kept_before = kept;
		px(1'b1, 1'b0, 12'h042, 12'h700);
		chkpx(16'h0000);
		chk(kept, kept_before);
		$display("test quick settle done");
		wrap_up();
	end
endmodule : tb_dlc_core
